// ==== sqc_pkg.sv ====
package sqc_pkg;
  // clocking and converter timing
  localparam int CLK_MHZ = 100;
  localparam int ADC_FMAX_MHZ = 18;
  localparam int DIV_MIN = (CLK_MHZ + ADC_FMAX_MHZ - 1) / ADC_FMAX_MHZ;
  localparam int CONV_MIN_CLKS = 18;
  localparam int RES_BITS = 12;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int SAMPLE_MIN = CONV_MIN_CLKS - RES_BITS;
  localparam int WAKE_US = 35;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int WAKE_W = $clog2(WAKE_CYC + 1);

  // register byte offsets
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_CLKDIV = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_LIMIT = 8'h10;
  localparam logic [7:0] REG_INT_STAT = 8'h14;
  localparam logic [7:0] REG_INT_CLR = 8'h18;
  localparam logic [7:0] REG_INT_EN = 8'h1c;
  localparam logic [2:0] REG_SAMP_RGN = 3'h2;
  localparam logic [2:0] REG_RES_RGN = 3'h4;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FW_BIT = 1;
  localparam int CTRL_CONT_BIT = 2;
  localparam int CTRL_FWCH_LSB = 4;
  localparam int CTRL_MASK_LSB = 8;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_CH_LSB = 4;
  localparam int LIM_HI_LSB = 16;
  localparam int RES_NEW_BIT = 16;
  localparam int RES_OOR_BIT = 17;
  localparam int INT_W = 3;
  localparam int INT_EOS = 0;
  localparam int INT_OOR = 1;
  localparam int INT_DONE = 2;

  // reset values
  localparam logic [7:0] CLKDIV_RST = 8'h06;
  localparam logic [7:0] SAMP_RST = 8'h06;
  localparam logic [11:0] LIM_LO_RST = 12'h000;
  localparam logic [11:0] LIM_HI_RST = 12'hfff;

  typedef enum logic [1:0] {
    SQC_IDLE = 2'b00,
    SQC_SAMPLE = 2'b01,
    SQC_CONV = 2'b11
  } sqc_state_t;
endpackage : sqc_pkg

// ==== sqc_res_if.sv ====
`timescale 1ns/1ns
// one finished conversion, valid for one cycle
interface sqc_res_if;
  logic valid;
  logic [2:0] chan;
  logic [11:0] data;
  modport src (output valid, output chan, output data);
  modport dst (input valid, input chan, input data);
endinterface : sqc_res_if

// ==== sqc_range_chk.sv ====
`timescale 1ns/1ns
// window compare of each result as it appears
module sqc_range_chk (
  sqc_res_if.dst res,
  input wire logic [11:0] lo_i,
  input wire logic [11:0] hi_i,
  output logic oor_o
);
  // below low or above high limit
  assign oor_o = res.valid && ((res.data < lo_i) || (res.data > hi_i)); // [R9] [R10]
endmodule : sqc_range_chk

// ==== sqc_sar_core.sv ====
`timescale 1ns/1ns
// sample window then one bit decision per converter tick
module sqc_sar_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic abort_i,
  input wire logic start_i,
  input wire logic [2:0] chan_i,
  input wire logic [7:0] samp_i,
  input wire logic cmp_i,
  output logic accept_o,
  output logic busy_o,
  output logic sample_o,
  output logic [2:0] chan_o,
  output logic [11:0] dac_o,
  sqc_res_if.src res
);
  localparam int TK_LAST = sqc_pkg::CONV_MIN_CLKS - 1;
  sqc_pkg::sqc_state_t state_q;
  logic [7:0] cnt_q;
  logic [11:0] bit_q;
  logic [11:0] decided;
  logic [7:0] samp_eff;
  logic [5:0] tk_q;

  // keep bit when input at or above trial level
  assign decided = cmp_i ? dac_o : (dac_o & ~bit_q);
  assign samp_eff = (samp_i < 8'(sqc_pkg::SAMPLE_MIN)) ? 8'(sqc_pkg::SAMPLE_MIN) : samp_i; // [R3]
  // start only on a converter tick, so a sample window is never a partial tick short
  // next conversion may start on the last bit tick
  assign accept_o = start_i && !abort_i && tick_i &&
                    ((state_q == sqc_pkg::SQC_IDLE) ||
                     ((state_q == sqc_pkg::SQC_CONV) && bit_q[0])); // [R2] [R5]
  assign busy_o = (state_q != sqc_pkg::SQC_IDLE);

  // converter sequence
  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      state_q <= sqc_pkg::SQC_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 12'h000;
      dac_o <= 12'h000;
      sample_o <= 1'b0;
      chan_o <= 3'h0;
    end else if (accept_o) begin
      state_q <= sqc_pkg::SQC_SAMPLE;
      cnt_q <= samp_eff; // [R8]
      chan_o <= chan_i; // [R4]
      sample_o <= 1'b1;
    end else begin
      unique case (state_q)
        sqc_pkg::SQC_IDLE: begin
          sample_o <= 1'b0;
        end
        sqc_pkg::SQC_SAMPLE: begin
          if (tick_i) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
              state_q <= sqc_pkg::SQC_CONV;
              sample_o <= 1'b0;
              bit_q <= 12'h800;
              dac_o <= 12'h800;
            end
          end
        end
        sqc_pkg::SQC_CONV: begin
          if (tick_i) begin
            bit_q <= bit_q >> 1;
            dac_o <= decided | (bit_q >> 1);
            if (bit_q[0]) begin
              state_q <= sqc_pkg::SQC_IDLE;
            end
          end
        end
      endcase
    end
  end

  // result strobe, one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res.valid <= 1'b0;
      res.data <= 12'h000;
      res.chan <= 3'h0;
    end else begin
      res.valid <= !abort_i && (state_q == sqc_pkg::SQC_CONV) && tick_i && bit_q[0];
      if ((state_q == sqc_pkg::SQC_CONV) && tick_i && bit_q[0]) begin
        res.data <= decided;
        res.chan <= chan_o;
      end
    end
  end

  // ticks since acceptance, checked only
  always_ff @(posedge clk_i) begin
    if (rst_i || accept_o) begin
      tk_q <= 6'h00;
    end else if (tick_i && tk_q != 6'h3f) begin
      tk_q <= tk_q + 6'h01;
    end
  end

  property p_conv_len;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == sqc_pkg::SQC_CONV && tick_i && bit_q[0]) |-> (tk_q >= 6'(TK_LAST));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion shorter than minimum"); // [R2]

  property p_sample_len;
    @(posedge clk_i) disable iff (rst_i)
    accept_o |=> sample_o && (cnt_q >= 8'(sqc_pkg::SAMPLE_MIN));
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample window not applied"); // [R8]
endmodule : sqc_sar_core

// ==== sqc_seq_top.sv ====
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Function
// R1 - converter clock never above 18 MHz
// R2 - conversion lasts at least 18 converter clocks
// R3 - sample window length is programmable
// R4 - one of eight input channels selected
// R5 - scan steps channels with no idle gap
// R6 - sequencer or firmware chooses each channel
// R7 - separate result buffer per channel
// R8 - each channel applies its own sample time
// R9 - low/high limits raise out-of-range interrupt
// R10 - each result range-checked as produced
// R11 - no conversions during deepest sleep
// R12 - deep sleep stops converter, 35 us wake
// R13 - end of scan flagged, continuous restarts
module sqc_seq_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic deep_sleep_i,
  input wire logic sar_cmp_i,
  output logic sar_en_o,
  output logic sar_sample_o,
  output logic [2:0] sar_chan_o,
  output logic [11:0] sar_dac_o
);
  // synchronisers
  logic ds_m_q, ds_q, cmp_m_q, cmp_q;
  // control registers
  logic en_q, fw_q, cont_q;
  logic [2:0] fwch_q;
  logic [7:0] mask_q, div_q;
  logic [11:0] lo_q, hi_q;
  logic [7:0] samp_q [8];
  logic [11:0] res_q [8];
  logic [7:0] new_q, oorf_q;
  logic [2:0] stat_q, ien_q;
  // sequencer and clocking
  logic [7:0] todo_q, rem, div_cnt_q, div_eff;
  logic eos_pend_q, eos_last_q, tick_q, ready_q;
  logic [sqc_pkg::WAKE_W-1:0] wake_q;
  logic [2:0] pick;
  logic start, accept, busy, oor;
  logic [2:0] ev;
  // bus
  logic wr_hit, rd_hit, start_cmd, stop_cmd;
  logic [31:0] rd_w, wmask, mw;
  logic [2:0] idx;

  sqc_res_if u_res ();

  // input synchronisers for pin-side levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ds_m_q <= 1'b0;
      ds_q <= 1'b0;
      cmp_m_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      ds_m_q <= deep_sleep_i;
      ds_q <= ds_m_q;
      cmp_m_q <= sar_cmp_i;
      cmp_q <= cmp_m_q;
    end
  end

  // wake timer after deep sleep ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_q <= '0;
      ready_q <= 1'b1;
      sar_en_o <= 1'b1;
    end else if (ds_q) begin
      wake_q <= sqc_pkg::WAKE_W'(sqc_pkg::WAKE_CYC); // [R12]
      ready_q <= 1'b0; // [R11]
      sar_en_o <= 1'b0; // [R12]
    end else begin
      sar_en_o <= 1'b1;
      if (wake_q != '0) begin
        wake_q <= wake_q - sqc_pkg::WAKE_W'(1);
      end
      ready_q <= (wake_q == '0);
    end
  end

  // converter clock divider, never below the minimum ratio
  assign div_eff = (div_q < 8'(sqc_pkg::DIV_MIN)) ? 8'(sqc_pkg::DIV_MIN) : div_q; // [R1]
  always_ff @(posedge clk_i) begin
    if (rst_i || !sar_en_o) begin
      div_cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_cnt_q == 8'h00);
      div_cnt_q <= (div_cnt_q == 8'h00) ? div_eff - 8'h01 : div_cnt_q - 8'h01;
    end
  end

  // lowest pending channel
  always_comb begin
    pick = 3'h0;
    for (int i = sqc_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (todo_q[i]) begin
        pick = 3'(i);
      end
    end
  end

  assign start = en_q && ready_q && (todo_q != 8'h00); // [R11]
  assign rem = todo_q & ~(8'h01 << pick);

  sqc_sar_core u_core (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_q),
    .abort_i(ds_q || !en_q),
    .start_i(start),
    .chan_i(pick),
    .samp_i(samp_q[pick]),
    .cmp_i(cmp_q),
    .accept_o(accept),
    .busy_o(busy),
    .sample_o(sar_sample_o),
    .chan_o(sar_chan_o),
    .dac_o(sar_dac_o),
    .res(u_res.src)
  );

  sqc_range_chk u_range (
    .res(u_res.dst),
    .lo_i(lo_q),
    .hi_i(hi_q),
    .oor_o(oor)
  );

  // scan list: firmware picks one channel, sequencer takes the mask
  always_ff @(posedge clk_i) begin
    if (rst_i || ds_q || !en_q || stop_cmd) begin
      todo_q <= 8'h00;
    end else if (start_cmd && ready_q) begin
      todo_q <= fw_q ? (8'h01 << fwch_q) : mask_q; // [R6]
    end else if (accept) begin
      todo_q <= (rem == 8'h00 && cont_q && !fw_q) ? mask_q : rem; // [R5] [R13]
    end
  end

  // last-channel flag of the conversion now in the core
  always_ff @(posedge clk_i) begin
    if (rst_i || ds_q || !en_q) begin
      eos_pend_q <= 1'b0;
    end else if (accept) begin
      eos_pend_q <= (rem == 8'h00); // [R13]
    end
  end

  // flag of the conversion whose result is out now; the next accept shares its edge
  always_ff @(posedge clk_i) begin
    if (rst_i || ds_q || !en_q) begin
      eos_last_q <= 1'b0;
    end else begin
      eos_last_q <= eos_pend_q; // [R13]
    end
  end

  // events of this cycle
  always_comb begin
    ev = 3'h0;
    ev[sqc_pkg::INT_EOS] = u_res.valid && eos_last_q; // [R13]
    ev[sqc_pkg::INT_OOR] = oor; // [R9] [R10]
    ev[sqc_pkg::INT_DONE] = u_res.valid;
  end

  // bus strobes
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign idx = wb_adr_i[4:2];
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign mw = (rd_w & ~wmask) | (wb_dat_i & wmask);
  assign start_cmd = wr_hit && (wb_adr_i == sqc_pkg::REG_CMD) && wb_sel_i[0] && wb_dat_i[sqc_pkg::CMD_START_BIT];
  assign stop_cmd = wr_hit && (wb_adr_i == sqc_pkg::REG_CMD) && wb_sel_i[0] && wb_dat_i[sqc_pkg::CMD_STOP_BIT];

  // read view of the register map
  always_comb begin
    rd_w = 32'h0000_0000;
    case (wb_adr_i)
      sqc_pkg::REG_CTRL: begin
        rd_w[sqc_pkg::CTRL_EN_BIT] = en_q;
        rd_w[sqc_pkg::CTRL_FW_BIT] = fw_q;
        rd_w[sqc_pkg::CTRL_CONT_BIT] = cont_q;
        rd_w[sqc_pkg::CTRL_FWCH_LSB +: 3] = fwch_q;
        rd_w[sqc_pkg::CTRL_MASK_LSB +: 8] = mask_q;
      end
      sqc_pkg::REG_CLKDIV: rd_w[7:0] = div_q;
      sqc_pkg::REG_STATUS: begin
        rd_w[sqc_pkg::STAT_BUSY_BIT] = busy || (todo_q != 8'h00);
        rd_w[sqc_pkg::STAT_READY_BIT] = ready_q;
        rd_w[sqc_pkg::STAT_CH_LSB +: 3] = sar_chan_o;
      end
      sqc_pkg::REG_LIMIT: begin
        rd_w[11:0] = lo_q;
        rd_w[sqc_pkg::LIM_HI_LSB +: 12] = hi_q;
      end
      sqc_pkg::REG_INT_STAT: rd_w[2:0] = stat_q;
      sqc_pkg::REG_INT_EN: rd_w[2:0] = ien_q;
      default: begin
        if (wb_adr_i[7:5] == sqc_pkg::REG_SAMP_RGN) begin
          rd_w[7:0] = samp_q[idx];
        end else if (wb_adr_i[7:5] == sqc_pkg::REG_RES_RGN) begin
          rd_w[11:0] = res_q[idx];
          rd_w[sqc_pkg::RES_NEW_BIT] = new_q[idx];
          rd_w[sqc_pkg::RES_OOR_BIT] = oorf_q[idx];
        end
      end
    endcase
  end

  // bus answer, one wait cycle, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_hit ? rd_w : 32'h0000_0000;
    end
  end

  // software-written control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      fw_q <= 1'b0;
      cont_q <= 1'b0;
      fwch_q <= 3'h0;
      mask_q <= 8'h00;
      div_q <= sqc_pkg::CLKDIV_RST;
      lo_q <= sqc_pkg::LIM_LO_RST;
      hi_q <= sqc_pkg::LIM_HI_RST;
      ien_q <= 3'h0;
    end else if (wr_hit) begin
      case (wb_adr_i)
        sqc_pkg::REG_CTRL: begin
          en_q <= mw[sqc_pkg::CTRL_EN_BIT];
          fw_q <= mw[sqc_pkg::CTRL_FW_BIT]; // [R6]
          cont_q <= mw[sqc_pkg::CTRL_CONT_BIT];
          fwch_q <= mw[sqc_pkg::CTRL_FWCH_LSB +: 3];
          mask_q <= mw[sqc_pkg::CTRL_MASK_LSB +: 8];
        end
        sqc_pkg::REG_CLKDIV: div_q <= mw[7:0];
        sqc_pkg::REG_LIMIT: begin
          lo_q <= mw[11:0]; // [R9]
          hi_q <= mw[sqc_pkg::LIM_HI_LSB +: 12];
        end
        sqc_pkg::REG_INT_EN: ien_q <= mw[2:0];
        default: ;
      endcase
    end
  end

  // per-channel sample times
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < sqc_pkg::NUM_CH; i++) begin
        samp_q[i] <= sqc_pkg::SAMP_RST;
      end
    end else if (wr_hit && wb_adr_i[7:5] == sqc_pkg::REG_SAMP_RGN) begin
      samp_q[idx] <= mw[7:0]; // [R3] [R8]
    end
  end

  // per-channel result buffers, reading clears the new flag, a new result wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < sqc_pkg::NUM_CH; i++) begin
        res_q[i] <= 12'h000;
      end
      new_q <= 8'h00;
      oorf_q <= 8'h00;
    end else begin
      if (rd_hit && wb_adr_i[7:5] == sqc_pkg::REG_RES_RGN) begin
        new_q[idx] <= 1'b0;
      end
      if (u_res.valid) begin
        res_q[u_res.chan] <= u_res.data; // [R7]
        new_q[u_res.chan] <= 1'b1;
        oorf_q[u_res.chan] <= oor; // [R10]
      end
    end
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~((wr_hit && wb_adr_i == sqc_pkg::REG_INT_CLR) ? mw[2:0] : 3'h0)) | ev; // [R9]
    end
  end

  // level interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_q & ien_q);
    end
  end

  property p_tick_rate;
    @(posedge clk_i) disable iff (rst_i)
    tick_q |=> !tick_q [*5];
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("converter clock too fast"); // [R1]

  property p_zero_gap;
    @(posedge clk_i) disable iff (rst_i)
    (u_res.valid && start && $past(start)) |-> $past(accept);
  endproperty
  a_zero_gap: assert property (p_zero_gap) else $error("idle gap between channels"); // [R5]

  property p_buffer;
    @(posedge clk_i) disable iff (rst_i)
    u_res.valid |=> (res_q[$past(u_res.chan)] == $past(u_res.data)) && new_q[$past(u_res.chan)];
  endproperty
  a_buffer: assert property (p_buffer) else $error("result not buffered"); // [R7]

  property p_oor_irq;
    @(posedge clk_i) disable iff (rst_i)
    oor |=> stat_q[sqc_pkg::INT_OOR] ##1 (irq_o == ien_q[sqc_pkg::INT_OOR] || $past(|(stat_q & ien_q)));
  endproperty
  a_oor_irq: assert property (p_oor_irq) else $error("out-of-range not flagged"); // [R9]

  property p_sleep_stop;
    @(posedge clk_i) disable iff (rst_i)
    ds_q |=> !sar_en_o && !busy && (todo_q == 8'h00);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("converter active in deep sleep"); // [R11]

  property p_wake_wait;
    @(posedge clk_i) disable iff (rst_i)
    $fell(ds_q) |-> !ready_q [*8] ##0 (wake_q > sqc_pkg::WAKE_W'(sqc_pkg::WAKE_CYC - 8));
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("wake delay not kept"); // [R12]

  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
    (accept && rem == 8'h00 && cont_q && !fw_q && !start_cmd && !stop_cmd) |=> todo_q == $past(mask_q);
  endproperty
  a_restart: assert property (p_restart) else $error("continuous scan did not restart"); // [R13]
endmodule : sqc_seq_top

// ==== sqc_ana_model.sv ====
`timescale 1ns/1ns
// analog front end: per-channel inputs and the comparator
module sqc_ana_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic sample_i,
  input wire logic [2:0] chan_i,
  input wire logic [11:0] dac_i,
  input wire logic [95:0] vin_i,
  output logic cmp_o
);
  logic [11:0] held_q = 12'h000;
  logic junk_q = 1'b0;
  // track the selected input while the switch is closed, freeze at hold
  always_ff @(posedge clk_i) begin
    if (sample_i) begin
      held_q <= vin_i[chan_i*12 +: 12];
    end
    junk_q <= ~junk_q;
  end
  // unpowered comparator gives no usable answer
  assign cmp_o = en_i ? (held_q >= dac_i) : junk_q;
endmodule : sqc_ana_model

// ==== sqc_seq_top_tb.sv ====
`timescale 1ns/1ns
module sqc_seq_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sleep = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, irq, cmp, sar_en, sar_sample;
  logic [2:0] sar_chan;
  logic [11:0] sar_dac;
  logic [95:0] vin;
  int miscompares = 0;
  int check_count = 0;
  int hi_len [8];
  int gap [8];
  int hi_cnt = 0;
  int since_rise = 0;
  logic samp_d = 1'b0;

  sqc_seq_top u_sqc_seq_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .deep_sleep_i(sleep), .sar_cmp_i(cmp), .sar_en_o(sar_en), .sar_sample_o(sar_sample),
    .sar_chan_o(sar_chan), .sar_dac_o(sar_dac));
  sqc_ana_model u_sqc_ana_model (.clk_i(clk), .en_i(sar_en), .sample_i(sar_sample), .chan_i(sar_chan),
    .dac_i(sar_dac), .vin_i(vin), .cmp_o(cmp));

  // clock
  initial begin
    forever #5 clk = ~clk;
  end

  // sample window length and rise-to-rise spacing per channel
  always @(posedge clk) begin
    since_rise++;
    if (sar_sample === 1'b1 && samp_d !== 1'b1) begin
      gap[sar_chan] = since_rise;
      since_rise = 0;
      hi_cnt = 1;
    end else if (sar_sample === 1'b1) begin
      hi_cnt++;
    end else if (samp_d === 1'b1) begin
      hi_len[sar_chan] = hi_cnt;
    end
    samp_d = sar_sample;
  end

  task finish_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error at %0t: expected %h got %h", $time, exp, got);
      miscompares++;
    end
  endtask : chk

  // one classic cycle, held until ack is seen at a rising edge
  task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) miscompares++;
  endtask : wb_xfer

  task wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask : wb_wr

  task wb_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0000_0000, q);
    chk(exp, q);
  endtask : wb_chk

  task wait_int(input int b);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb_xfer(1'b0, sqc_pkg::REG_INT_STAT, 32'h0000_0000, q);
      n++;
    end while (q[b] !== 1'b1 && n < 3000);
    if (n >= 3000) miscompares++;
  endtask : wait_int

  function automatic logic [11:0] ev(input int c);
    return 12'h0a5 + 12'(c) * 12'h100;
  endfunction : ev

  task t_reset_vals;
    wb_chk(sqc_pkg::REG_CTRL, 32'h0000_0000);
    wb_chk(sqc_pkg::REG_CLKDIV, 32'h0000_0006);
    wb_chk(sqc_pkg::REG_LIMIT, 32'h0fff_0000);
    wb_chk(sqc_pkg::REG_INT_STAT, 32'h0000_0000);
    wb_chk(sqc_pkg::REG_INT_EN, 32'h0000_0000);
    for (int c = 0; c < 8; c++) wb_chk(8'h40 + 8'(4 * c), 32'h0000_0006);
    wb_wr(8'h30, 32'hffff_ffff);
    wb_chk(8'h30, 32'h0000_0000);
  endtask : t_reset_vals

  // full eight-channel scan, per-channel timing, range flags, interrupt
  task t_scan;
    logic [31:0] exp;
    for (int c = 0; c < 8; c++) wb_wr(8'h40 + 8'(4 * c), 32'(6 + c));
    wb_wr(sqc_pkg::REG_LIMIT, 32'h0600_0150);
    wb_wr(sqc_pkg::REG_INT_EN, 32'h0000_0002);
    wb_wr(sqc_pkg::REG_CTRL, 32'h0000_ff01);
    wb_wr(sqc_pkg::REG_CMD, 32'h0000_0001);
    wait_int(sqc_pkg::INT_EOS);
    chk(32'h1, {31'h0, irq});
    wb_chk(sqc_pkg::REG_INT_STAT, 32'h0000_0007);
    for (int c = 0; c < 8; c++) begin
      exp = {14'h0, (ev(c) < 12'h150 || ev(c) > 12'h600), 1'b1, 4'h0, ev(c)};
      wb_chk(8'h80 + 8'(4 * c), exp);
      chk(32'((6 + c) * 6), 32'(hi_len[c]));
      if (c > 0) chk(32'((c + 17) * 6), 32'(gap[c]));
    end
    wb_chk(8'h80, {16'h0002, 4'h0, ev(0)});
    wb_wr(sqc_pkg::REG_INT_EN, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(32'h0, {31'h0, irq});
    wb_wr(sqc_pkg::REG_INT_EN, 32'h0000_0002);
    wb_wr(sqc_pkg::REG_INT_CLR, 32'h0000_0007);
    wb_chk(sqc_pkg::REG_INT_STAT, 32'h0000_0000);
    chk(32'h0, {31'h0, irq});
  endtask : t_scan

  // firmware picks channel 5; divider below the floor acts as the floor
  task t_fw;
    int divs [2];
    divs = '{2, 7};
    for (int i = 0; i < 2; i++) begin
      wb_wr(sqc_pkg::REG_CLKDIV, 32'(divs[i]));
      wb_wr(sqc_pkg::REG_CTRL, 32'h0000_0053);
      wb_wr(sqc_pkg::REG_CMD, 32'h0000_0001);
      wait_int(sqc_pkg::INT_DONE);
      wb_wr(sqc_pkg::REG_INT_CLR, 32'h0000_0007);
      wb_chk(8'h94, {16'h0001, 4'h0, ev(5)});
      wb_chk(8'h90, {16'h0000, 4'h0, ev(4)});
      chk(32'(11 * (divs[i] < 6 ? 6 : divs[i])), 32'(hi_len[5]));
    end
    wb_wr(sqc_pkg::REG_CLKDIV, 32'h0000_0006);
  endtask : t_fw

  // continuous scan restarts with no gap, stop ends it
  task t_cont;
    logic [31:0] q;
    wb_wr(sqc_pkg::REG_CTRL, 32'h0000_0305);
    wb_wr(sqc_pkg::REG_CMD, 32'h0000_0001);
    wait_int(sqc_pkg::INT_EOS);
    wb_wr(sqc_pkg::REG_INT_CLR, 32'h0000_0001);
    wait_int(sqc_pkg::INT_EOS);
    chk(32'(19 * 6), 32'(gap[0]));
    wb_wr(sqc_pkg::REG_CMD, 32'h0000_0002);
    repeat (250) @(posedge clk);
    wb_xfer(1'b0, sqc_pkg::REG_STATUS, 32'h0000_0000, q);
    chk(32'h0, {31'h0, q[sqc_pkg::STAT_BUSY_BIT]});
    wb_wr(sqc_pkg::REG_INT_CLR, 32'h0000_0007);
  endtask : t_cont

  // deep sleep powers down, refuses start, wakes after the fixed delay
  task t_sleep;
    logic [31:0] q;
    time t0;
    @(posedge clk);
    sleep <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'h0, {31'h0, sar_en});
    wb_wr(sqc_pkg::REG_CTRL, 32'h0000_0003);
    wb_wr(sqc_pkg::REG_CMD, 32'h0000_0001);
    repeat (20) @(posedge clk);
    wb_xfer(1'b0, sqc_pkg::REG_STATUS, 32'h0000_0000, q);
    chk(32'h0, {30'h0, q[1:0]});
    @(posedge clk);
    sleep <= 1'b0;
    t0 = $time;
    do begin
      wb_xfer(1'b0, sqc_pkg::REG_STATUS, 32'h0000_0000, q);
    end while (q[sqc_pkg::STAT_READY_BIT] !== 1'b1 && $time - t0 < 60000);
    chk(32'h1, 32'(($time - t0) / 10 >= sqc_pkg::WAKE_CYC));
    chk(32'h1, 32'(($time - t0) / 10 < sqc_pkg::WAKE_CYC + 40));
    chk(32'h1, {31'h0, sar_en});
  endtask : t_sleep

  // hang guard
  initial begin
    #200_000;
    miscompares++;
    finish_test;
  end

  initial begin
    for (int c = 0; c < 8; c++) vin[c*12 +: 12] = ev(c);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals;
    t_scan;
    t_fw;
    t_cont;
    t_sleep;
    finish_test;
  end
endmodule : sqc_seq_top_tb
